// >>> design/qcr_register_set.sv
// quadrature counter register set behind an axi4-lite slave
//
// The AXI4-Lite slave port and the register addresses were left to the implementer.
`default_nettype none

module qcr_register_set
	import qcr_pkg::*;
#(
	parameter bit VEL_HIGH_EN = 1'b1
) (
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic [2:0]  s_axi_awprot,
	input  wire logic        s_axi_awvalid,
	output var  logic        s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output var  logic        s_axi_wready,
	output var  logic [1:0]  s_axi_bresp,
	output var  logic        s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic [2:0]  s_axi_arprot,
	input  wire logic        s_axi_arvalid,
	output var  logic        s_axi_arready,
	output var  logic [31:0] s_axi_rdata,
	output var  logic [1:0]  s_axi_rresp,
	output var  logic        s_axi_rvalid,
	input  wire logic        s_axi_rready,
	input  wire logic        count_up,
	input  wire logic        count_down,
	input  wire logic        index_event,
	input  wire logic        home_event,
	input  wire logic        homing_reinit,
	output var  logic        irq
);

	// ----------------------------------------------------------------
	// bus channel state
	// ----------------------------------------------------------------
	logic        awready_reg;
	logic        wready_reg;
	logic        bvalid_reg;
	logic [1:0]  bresp_reg;
	logic        arready_reg;
	logic        rvalid_reg;
	logic [1:0]  rresp_reg;
	logic [31:0] rdata_reg;
	logic [7:0]  aw_addr_reg;
	logic [15:0] w_data_reg;
	logic [1:0]  w_strb_reg;
	logic        irq_reg;

	// ----------------------------------------------------------------
	// register contents
	// ----------------------------------------------------------------
	logic        index_en_reg;
	logic        home_en_reg;
	logic        homing_en_reg;
	logic [2:0]  mode_reg;
	logic [15:0] mask_reg;
	logic [31:0] ihold_reg;
	logic        index_flag;
	logic        home_flag;
	logic        homing_flag;
	logic [31:0] pos_value;
	logic [15:0] pos_hold;
	logic [31:0] vel_value;
	logic [15:0] vel_hold;
	logic [31:0] int_value;
	logic [15:0] status_word;
	logic [15:0] flag_bits;
	logic [15:0] enable_bits;

	// ----------------------------------------------------------------
	// decode
	// ----------------------------------------------------------------
	logic        aw_take;
	logic        w_take;
	logic        ar_take;
	logic        wr_fire;
	logic        wr_mapped;
	logic        rd_mapped;
	logic [15:0] wr_cur;
	logic [15:0] rd_cur;
	logic [15:0] lane_mask;
	logic [15:0] wval;
	logic [15:0] clear_bits;
	logic        wr_status;
	logic        wr_pos_low;
	logic        wr_pos_high;
	logic        wr_pos_hold;
	logic        wr_vel_low;
	logic        wr_vel_high;
	logic        wr_vel_hold;
	logic        wr_int_low;
	logic        wr_int_high;
	logic        wr_ihold_low;
	logic        wr_ihold_high;
	logic        wr_mode;
	logic        wr_mask;
	logic        rd_pos_low;
	logic        rd_vel_low;
	logic        rd_int_low;
	logic        homing_mode;
	logic        homing_set;

	function automatic logic is_mapped(input logic [7:0] a);
		logic hit;
		hit = 1'b0;
		case (a)
			OFF_STATUS, OFF_POS_LOW, OFF_POS_HIGH, OFF_POS_HOLD,
			OFF_VEL_LOW, OFF_VEL_HOLD, OFF_INT_LOW, OFF_INT_HIGH,
			OFF_IHOLD_LOW, OFF_IHOLD_HIGH, OFF_MODE, OFF_IRQ_MASK: begin
				hit = 1'b1;
			end
			OFF_VEL_HIGH: begin
				hit = VEL_HIGH_EN;
			end
			default: begin
				hit = 1'b0;
			end
		endcase
		return hit;
	endfunction

	function automatic logic [15:0] reg_value(input logic [7:0] a);
		logic [15:0] v;
		v = WORD_RESET;
		case (a)
			OFF_STATUS:     v = status_word;
			OFF_POS_LOW:    v = pos_value[15:0];
			OFF_POS_HIGH:   v = pos_value[31:16];
			OFF_POS_HOLD:   v = pos_hold;
			OFF_VEL_LOW:    v = vel_value[15:0];
			OFF_VEL_HIGH:   v = vel_value[31:16];
			OFF_VEL_HOLD:   v = vel_hold;
			OFF_INT_LOW:    v = int_value[15:0];
			OFF_INT_HIGH:   v = int_value[31:16];
			OFF_IHOLD_LOW:  v = ihold_reg[15:0];
			OFF_IHOLD_HIGH: v = ihold_reg[31:16];
			OFF_MODE:       v = {13'h0000, mode_reg};
			OFF_IRQ_MASK:   v = mask_reg;
			default:        v = WORD_RESET;
		endcase
		return v;
	endfunction

	assign aw_take  = s_axi_awvalid & awready_reg;
	assign w_take   = s_axi_wvalid & wready_reg;
	assign ar_take  = s_axi_arvalid & arready_reg;
	// both halves of a write held and no answer pending
	assign wr_fire   = ~awready_reg & ~wready_reg & ~bvalid_reg;
	assign wr_mapped = is_mapped(aw_addr_reg);
	assign rd_mapped = is_mapped(s_axi_araddr);
	always_comb wr_cur = reg_value(aw_addr_reg);
	always_comb rd_cur = reg_value(s_axi_araddr);

	// partial writes keep the untouched byte of the current value
	assign lane_mask  = {{8{w_strb_reg[1]}}, {8{w_strb_reg[0]}}};
	assign wval       = (w_data_reg & lane_mask) | (wr_cur & ~lane_mask);
	assign clear_bits = w_data_reg & lane_mask;

	assign wr_status     = wr_fire & (aw_addr_reg == OFF_STATUS);
	assign wr_pos_low    = wr_fire & (aw_addr_reg == OFF_POS_LOW);
	assign wr_pos_high   = wr_fire & (aw_addr_reg == OFF_POS_HIGH);
	assign wr_pos_hold   = wr_fire & (aw_addr_reg == OFF_POS_HOLD);
	assign wr_vel_low    = wr_fire & (aw_addr_reg == OFF_VEL_LOW);
	assign wr_vel_high   = wr_fire & (aw_addr_reg == OFF_VEL_HIGH) & VEL_HIGH_EN;
	assign wr_vel_hold   = wr_fire & (aw_addr_reg == OFF_VEL_HOLD);
	assign wr_int_low    = wr_fire & (aw_addr_reg == OFF_INT_LOW);
	assign wr_int_high   = wr_fire & (aw_addr_reg == OFF_INT_HIGH);
	assign wr_ihold_low  = wr_fire & (aw_addr_reg == OFF_IHOLD_LOW);
	assign wr_ihold_high = wr_fire & (aw_addr_reg == OFF_IHOLD_HIGH);
	assign wr_mode       = wr_fire & (aw_addr_reg == OFF_MODE);
	assign wr_mask       = wr_fire & (aw_addr_reg == OFF_IRQ_MASK);

	// upper word is latched at the same edge the low word is sampled
	assign rd_pos_low = ar_take & (s_axi_araddr == OFF_POS_LOW);
	assign rd_vel_low = ar_take & (s_axi_araddr == OFF_VEL_LOW);
	assign rd_int_low = ar_take & (s_axi_araddr == OFF_INT_LOW);

	// ----------------------------------------------------------------
	// status and interrupt
	// ----------------------------------------------------------------
	assign homing_mode = (mode_reg == MODE_HOME_A) | (mode_reg == MODE_HOME_B);
	assign homing_set  = homing_reinit & homing_mode;

	always_comb begin
		status_word = WORD_RESET;
		status_word[BIT_INDEX_EN]   = index_en_reg;
		status_word[BIT_INDEX_FLAG] = index_flag;
		status_word[BIT_HOME_EN]    = home_en_reg;
		status_word[BIT_HOME_FLAG]  = home_flag;
		status_word[BIT_HOMING_EN]  = homing_en_reg;
		status_word[BIT_HOMING_FLG] = homing_flag;
	end

	always_comb begin
		flag_bits   = WORD_RESET;
		enable_bits = WORD_RESET;
		flag_bits[BIT_INDEX_FLAG]   = index_flag;
		flag_bits[BIT_HOME_FLAG]    = home_flag;
		flag_bits[BIT_HOMING_FLG]   = homing_flag;
		enable_bits[BIT_INDEX_FLAG] = index_en_reg;
		enable_bits[BIT_HOME_FLAG]  = home_en_reg;
		enable_bits[BIT_HOMING_FLG] = homing_en_reg;
	end

	qcr_sticky_flag u_index_flag (
		.aclk      (aclk),
		.aresetn   (aresetn),
		.set_event (index_event),
		.clear_req (wr_status & clear_bits[BIT_INDEX_FLAG]),
		.flag      (index_flag)
	);

	qcr_sticky_flag u_home_flag (
		.aclk      (aclk),
		.aresetn   (aresetn),
		.set_event (home_event),
		.clear_req (wr_status & clear_bits[BIT_HOME_FLAG]),
		.flag      (home_flag)
	);

	qcr_sticky_flag u_homing_flag (
		.aclk      (aclk),
		.aresetn   (aresetn),
		.set_event (homing_set),
		.clear_req (wr_status & clear_bits[BIT_HOMING_FLG]),
		.flag      (homing_flag)
	);

	// ----------------------------------------------------------------
	// counters
	// ----------------------------------------------------------------
	qcr_word_counter #(
		.HIGH_EN (1'b1)
	) u_position (
		.aclk        (aclk),
		.aresetn     (aresetn),
		.count_up    (count_up),
		.count_down  (count_down),
		.wr_low      (wr_pos_low),
		.wr_high     (wr_pos_high),
		.wr_hold     (wr_pos_hold),
		.rd_low      (rd_pos_low),
		.wval        (wval),
		.count_value (pos_value),
		.hold_value  (pos_hold)
	);

	qcr_word_counter #(
		.HIGH_EN (VEL_HIGH_EN)
	) u_velocity (
		.aclk        (aclk),
		.aresetn     (aresetn),
		.count_up    (count_up),
		.count_down  (count_down),
		.wr_low      (wr_vel_low),
		.wr_high     (wr_vel_high),
		.wr_hold     (wr_vel_hold),
		.rd_low      (rd_vel_low),
		.wval        (wval),
		.count_value (vel_value),
		.hold_value  (vel_hold)
	);

	// interval timer counts every clock; its hold word is unused here
	qcr_word_counter #(
		.HIGH_EN (1'b1)
	) u_interval (
		.aclk        (aclk),
		.aresetn     (aresetn),
		.count_up    (1'b1),
		.count_down  (1'b0),
		.wr_low      (wr_int_low),
		.wr_high     (wr_int_high),
		.wr_hold     (1'b0),
		.rd_low      (rd_int_low),
		.wval        (wval),
		.count_value (int_value),
		.hold_value  ()
	);

	// ----------------------------------------------------------------
	// software registers
	// ----------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			index_en_reg  <= 1'b0;
			home_en_reg   <= 1'b0;
			homing_en_reg <= 1'b0;
		end else if (wr_status) begin
			index_en_reg  <= wval[BIT_INDEX_EN];
			home_en_reg   <= wval[BIT_HOME_EN];
			homing_en_reg <= wval[BIT_HOMING_EN];
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			mode_reg  <= MODE_RESET;
			mask_reg  <= WORD_RESET;
			ihold_reg <= COUNT_RESET;
		end else begin
			if (wr_mode) begin
				mode_reg <= wval[MODE_W-1:0];
			end
			if (wr_mask) begin
				mask_reg <= wval & (16'h0001 << BIT_INDEX_FLAG | 16'h0001 << BIT_HOME_FLAG
					| 16'h0001 << BIT_HOMING_FLG);
			end
			if (wr_ihold_low) begin
				ihold_reg[15:0] <= wval;
			end
			if (wr_ihold_high) begin
				ihold_reg[31:16] <= wval;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			irq_reg <= 1'b0;
		end else begin
			irq_reg <= |(flag_bits & enable_bits & mask_reg);
		end
	end

	// ----------------------------------------------------------------
	// write channels
	// ----------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			awready_reg <= 1'b1;
			wready_reg  <= 1'b1;
			bvalid_reg  <= 1'b0;
			bresp_reg   <= RESP_OKAY;
			aw_addr_reg <= 8'h00;
			w_data_reg  <= WORD_RESET;
			w_strb_reg  <= 2'b00;
		end else begin
			if (aw_take) begin
				awready_reg <= 1'b0;
				aw_addr_reg <= s_axi_awaddr;
			end
			if (w_take) begin
				wready_reg <= 1'b0;
				w_data_reg <= s_axi_wdata[15:0];
				w_strb_reg <= s_axi_wstrb[1:0];
			end
			if (wr_fire) begin
				bvalid_reg <= 1'b1;
				bresp_reg  <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
			end
			if (bvalid_reg && s_axi_bready) begin
				bvalid_reg  <= 1'b0;
				awready_reg <= 1'b1;
				wready_reg  <= 1'b1;
			end
		end
	end

	// ----------------------------------------------------------------
	// read channels
	// ----------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready_reg <= 1'b1;
			rvalid_reg  <= 1'b0;
			rresp_reg   <= RESP_OKAY;
			rdata_reg   <= COUNT_RESET;
		end else if (ar_take) begin
			arready_reg <= 1'b0;
			rvalid_reg  <= 1'b1;
			rresp_reg   <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
			rdata_reg   <= {16'h0000, rd_cur};
		end else if (rvalid_reg && s_axi_rready) begin
			arready_reg <= 1'b1;
			rvalid_reg  <= 1'b0;
		end
	end

	assign s_axi_awready = awready_reg;
	assign s_axi_wready  = wready_reg;
	assign s_axi_bvalid  = bvalid_reg;
	assign s_axi_bresp   = bresp_reg;
	assign s_axi_arready = arready_reg;
	assign s_axi_rvalid  = rvalid_reg;
	assign s_axi_rresp   = rresp_reg;
	assign s_axi_rdata   = rdata_reg;
	assign irq           = irq_reg;

endmodule

`default_nettype wire

// >>> design/qcr_pkg.sv
// constants shared by the quadrature counter register set
//
// Contract
// - Status bit 2 is a read/write home event interrupt enable; when set a home event requests an interrupt if interrupt mask bit 3 is also set.
// - Status bit 1 is set by hardware on an index event and stays set until software clears it.
// - Status bit 0 is a read/write index event interrupt enable that gates the index event interrupt.
// - The homing complete flag is set only while the init mode field selects 3'b011 or 3'b100.
// - A 32-bit position count is held as a read/write low word and a read/write high word, both reset to zero.
// - A 16-bit position hold register carries the upper word of the position count for 32-bit access.
// - A 16-bit velocity hold register carries the velocity upper word through the hold path.
// - A 32-bit interval timer is held as a read/write low word and high word, both cleared at reset.
// - A 32-bit interval timer hold value has a read/write low word resetting to zero and a separate upper word.
// - The homing complete flag at status bit 7 is set when homing reinitialised the position count.
// - The home event flag at status bit 3 is set by hardware on a home event and cleared by software.
`default_nettype none

package qcr_pkg;

	// ----------------------------------------------------------------
	// register byte offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] OFF_STATUS     = 8'h00;
	localparam logic [7:0] OFF_POS_LOW    = 8'h04;
	localparam logic [7:0] OFF_POS_HIGH   = 8'h08;
	localparam logic [7:0] OFF_POS_HOLD   = 8'h0c;
	localparam logic [7:0] OFF_VEL_LOW    = 8'h10;
	localparam logic [7:0] OFF_VEL_HIGH   = 8'h14;
	localparam logic [7:0] OFF_VEL_HOLD   = 8'h18;
	localparam logic [7:0] OFF_INT_LOW    = 8'h1c;
	localparam logic [7:0] OFF_INT_HIGH   = 8'h20;
	localparam logic [7:0] OFF_IHOLD_LOW  = 8'h24;
	localparam logic [7:0] OFF_IHOLD_HIGH = 8'h28;
	localparam logic [7:0] OFF_MODE       = 8'h2c;
	localparam logic [7:0] OFF_IRQ_MASK   = 8'h30;

	// ----------------------------------------------------------------
	// status field positions
	// ----------------------------------------------------------------
	localparam int BIT_INDEX_EN   = 0;
	localparam int BIT_INDEX_FLAG = 1;
	localparam int BIT_HOME_EN    = 2;
	localparam int BIT_HOME_FLAG  = 3;
	localparam int BIT_HOMING_EN  = 6;
	localparam int BIT_HOMING_FLG = 7;

	// ----------------------------------------------------------------
	// init mode field and reset values
	// ----------------------------------------------------------------
	localparam int         MODE_W          = 3;
	localparam logic [2:0] MODE_HOME_A     = 3'b011;
	localparam logic [2:0] MODE_HOME_B     = 3'b100;
	localparam logic [2:0] MODE_RESET      = 3'b000;
	localparam logic [15:0] WORD_RESET     = 16'h0000;
	localparam logic [31:0] COUNT_RESET    = 32'h0000_0000;

	// ----------------------------------------------------------------
	// bus answers
	// ----------------------------------------------------------------
	localparam logic [1:0] RESP_OKAY   = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;

endpackage

`default_nettype wire

// >>> design/qcr_sticky_flag.sv
// hardware-set, software-cleared status flag
`default_nettype none

module qcr_sticky_flag
	import qcr_pkg::*;
(
	input  wire logic aclk,
	input  wire logic aresetn,
	input  wire logic set_event,
	input  wire logic clear_req,
	output var  logic flag
);

	logic flag_reg;
	logic flag_next;

	// set wins so an event in the clearing cycle survives
	assign flag_next = set_event | (flag_reg & ~clear_req);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			flag_reg <= 1'b0;
		end else begin
			flag_reg <= flag_next;
		end
	end

	assign flag = flag_reg;

endmodule

`default_nettype wire

// >>> design/qcr_word_counter.sv
// 32-bit up/down counter seen as two 16-bit words plus an upper-word hold
`default_nettype none

module qcr_word_counter
	import qcr_pkg::*;
#(
	parameter bit HIGH_EN = 1'b1
) (
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic        count_up,
	input  wire logic        count_down,
	input  wire logic        wr_low,
	input  wire logic        wr_high,
	input  wire logic        wr_hold,
	input  wire logic        rd_low,
	input  wire logic [15:0] wval,
	output var  logic [31:0] count_value,
	output var  logic [15:0] hold_value
);

	logic [31:0] count_reg;
	logic [31:0] count_next;
	logic [31:0] count_raw;
	logic [15:0] hold_reg;
	logic [15:0] hold_next;
	logic [31:0] upper_mask;

	// without a high word the counter wraps at 16 bits
	assign upper_mask = HIGH_EN ? 32'hffff_ffff : 32'h0000_ffff;

	always_comb begin
		count_raw = count_reg;
		if (wr_low) begin
			count_raw = {hold_reg, wval};
		end else if (wr_high) begin
			count_raw = {wval, count_reg[15:0]};
		end else if (count_up && !count_down) begin
			count_raw = count_reg + 32'h0000_0001;
		end else if (count_down && !count_up) begin
			count_raw = count_reg - 32'h0000_0001;
		end
		count_next = count_raw & upper_mask;
	end

	// software writes to hold beat a read latch in the same cycle
	assign hold_next = wr_hold ? wval :
		(rd_low ? count_value[31:16] : hold_reg);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			count_reg <= COUNT_RESET;
			hold_reg  <= WORD_RESET;
		end else begin
			count_reg <= count_next;
			hold_reg  <= hold_next;
		end
	end

	assign count_value = count_reg;
	assign hold_value  = hold_reg;

endmodule

`default_nettype wire

// >>> sim/qcr_register_set_properties.sv
// bus and register checks bound to the quadrature counter register set
`default_nettype none

module qcr_register_set_properties
	import qcr_pkg::*;
(
	input wire logic        aclk,
	input wire logic        aresetn,
	input wire logic [7:0]  s_axi_awaddr,
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic [1:0]  s_axi_bresp,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic [7:0]  s_axi_araddr,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0]  s_axi_rresp,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready
);
	timeunit 1ns;
	timeprecision 100ps;

	// ----------------------------------------------------------------
	// handshake decode
	// ----------------------------------------------------------------
	wire logic wr_go = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	wire logic rd_go = s_axi_arvalid && s_axi_arready;
	wire logic bad_wa = (s_axi_awaddr > OFF_IRQ_MASK) || (s_axi_awaddr[1:0] != 2'b00);
	wire logic bad_ra = (s_axi_araddr > OFF_IRQ_MASK) || (s_axi_araddr[1:0] != 2'b00);

	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	a_b_stands: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped before bready");
	a_r_stands: assert property (s_axi_rvalid && !s_axi_rready |=>
		s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
		else $error("read data changed before rready");
	a_rdata_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000)
		else $error("upper read half not zero");
	a_aw_blocked: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("new write accepted while response pending");
	a_ar_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("new read accepted while data pending");
	a_read_answer: assert property (rd_go |=> s_axi_rvalid)
		else $error("read not answered one cycle after address");
	a_write_answer: assert property (wr_go |-> ##2 s_axi_bvalid)
		else $error("write not answered two cycles after transfer");
	a_rd_error: assert property (rd_go && bad_ra |=>
		s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0000_0000)
		else $error("unmapped read not refused");
	a_wr_error: assert property (wr_go && bad_wa |-> ##2 s_axi_bresp == RESP_SLVERR)
		else $error("unmapped write not refused");
	a_rd_okay: assert property (rd_go && !bad_ra |=> s_axi_rresp == RESP_OKAY)
		else $error("mapped read refused");
endmodule

bind qcr_register_set qcr_register_set_properties u_props (.aclk, .aresetn, .s_axi_awaddr,
	.s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
	.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
	.s_axi_rvalid, .s_axi_rready);

`default_nettype wire

// >>> sim/qcr_encoder_model.sv
// behavioural incremental encoder driving count and event strobes
`default_nettype none

module qcr_encoder_model (
	input  wire logic aclk,
	output var  logic count_up,
	output var  logic count_down,
	output var  logic index_event,
	output var  logic home_event,
	output var  logic homing_reinit
);
	timeunit 1ns;
	timeprecision 100ps;

	// ----------------------------------------------------------------
	// stimulus tasks
	// ----------------------------------------------------------------
	initial begin
		count_up = 1'b0;
		count_down = 1'b0;
		index_event = 1'b0;
		home_event = 1'b0;
		homing_reinit = 1'b0;
	end

	// gap stretches pulse spacing to mimic a slowly turning shaft
	task automatic move(input int n, input bit down, input int gap);
		repeat (n) begin
			@(posedge aclk);
			count_up <= !down;
			count_down <= down;
			@(posedge aclk);
			count_up <= 1'b0;
			count_down <= 1'b0;
			repeat (gap) @(posedge aclk);
		end
	endtask

	// single-cycle strobe: 0 index, 1 home, 2 homing reinit
	task automatic strobe(input int which);
		@(posedge aclk);
		index_event <= (which == 0);
		home_event <= (which == 1);
		homing_reinit <= (which == 2);
		@(posedge aclk);
		index_event <= 1'b0;
		home_event <= 1'b0;
		homing_reinit <= 1'b0;
	endtask
endmodule

`default_nettype wire

// >>> sim/qcr_register_set_tb_top.sv
// self-checking bench for the quadrature counter register set
`default_nettype none

module qcr_register_set_tb_top
	import qcr_pkg::*;
();
	timeunit 1ns;
	timeprecision 100ps;

	// ----------------------------------------------------------------
	// signals, instances and bus tasks
	// ----------------------------------------------------------------
	logic        aclk, aresetn, irq, count_up, count_down;
	logic        index_event, home_event, homing_reinit;
	logic [7:0]  s_axi_awaddr, s_axi_araddr;
	logic [2:0]  s_axi_awprot, s_axi_arprot;
	logic [31:0] s_axi_wdata, s_axi_rdata, rdv;
	logic [3:0]  s_axi_wstrb;
	logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
	logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
	logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	int          miscompares, n_checks, stall, cyc;
	logic [7:0]  rst_offs [11] = '{OFF_STATUS, OFF_POS_LOW, OFF_POS_HIGH, OFF_POS_HOLD,
		OFF_VEL_LOW, OFF_VEL_HIGH, OFF_VEL_HOLD, OFF_IHOLD_LOW, OFF_IHOLD_HIGH, OFF_MODE,
		OFF_IRQ_MASK};
	logic [7:0]  rw_offs [6] = '{OFF_POS_HIGH, OFF_POS_HOLD, OFF_VEL_HIGH, OFF_VEL_HOLD,
		OFF_IHOLD_LOW, OFF_IHOLD_HIGH};

	qcr_register_set DUT (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid,
		.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .count_up,
		.count_down, .index_event, .home_event, .homing_reinit, .irq);
	qcr_encoder_model enc (.aclk, .count_up, .count_down, .index_event, .home_event,
		.homing_reinit);

	always #25 aclk = ~aclk;

	task automatic close_out();
		if (miscompares == 0 && n_checks > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask

	always @(posedge aclk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			miscompares++;
			close_out();
		end
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("mismatch at %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	// stall holds the response ready low for that many cycles
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= (stall == 0);
		do begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
			n++;
			if (n >= stall) s_axi_bready <= 1'b1;
		end while (!(s_axi_bvalid && s_axi_bready));
		rsp = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a);
		int n;
		n = 0;
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= (stall == 0);
		do begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
			n++;
			if (n >= stall) s_axi_rready <= 1'b1;
		end while (!(s_axi_rvalid && s_axi_rready));
		rdv = s_axi_rdata;
		rsp = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask

	task automatic expect_rd(input logic [7:0] a, input logic [31:0] exp);
		rd(a);
		check(rdv, exp);
	endtask

	task automatic irq_after(input logic e);
		repeat (2) @(posedge aclk);
		check({31'h0, irq}, {31'h0, e});
	endtask

	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task automatic t_read_write();
		foreach (rst_offs[i]) expect_rd(rst_offs[i], 32'h0);
		stall = 3;
		foreach (rw_offs[i]) begin
			wr(rw_offs[i], 32'hffff_a5c3);
			expect_rd(rw_offs[i], 32'h0000_a5c3);
			wr(rw_offs[i], 32'h0);
		end
		s_axi_wstrb <= 4'h1;
		wr(OFF_POS_HOLD, 32'h1234);
		s_axi_wstrb <= 4'h3;
		expect_rd(OFF_POS_HOLD, 32'h0034);
		stall = 0;
	endtask

	task automatic t_hold_path();
		wr(OFF_POS_HOLD, 32'h1234);
		wr(OFF_POS_LOW, 32'habcd);
		check({30'h0, rsp}, {30'h0, RESP_OKAY});
		expect_rd(OFF_POS_HIGH, 32'h1234);
		enc.move(3, 1'b0, 0);
		enc.move(1, 1'b1, 2);
		expect_rd(OFF_POS_LOW, 32'habcf);
		wr(OFF_POS_HIGH, 32'h0);
		expect_rd(OFF_POS_HOLD, 32'h1234);
		wr(OFF_POS_HOLD, 32'h0001);
		wr(OFF_POS_LOW, 32'h0);
		enc.move(1, 1'b1, 0);
		expect_rd(OFF_POS_LOW, 32'hffff);
		expect_rd(OFF_POS_HIGH, 32'h0);
		expect_rd(OFF_VEL_LOW, 32'h0001);
		wr(OFF_VEL_HOLD, 32'h0002);
		wr(OFF_VEL_LOW, 32'h0005);
		expect_rd(OFF_VEL_HIGH, 32'h0002);
	endtask

	task automatic t_timer();
		logic [31:0] a;
		rd(OFF_INT_LOW);
		a = rdv;
		rd(OFF_INT_LOW);
		check(32'(rdv > a), 32'h1);
		wr(OFF_INT_HIGH, 32'h0055);
		expect_rd(OFF_INT_HIGH, 32'h0055);
	endtask

	task automatic t_events();
		wr(OFF_IRQ_MASK, 32'h8a);
		enc.strobe(0);
		expect_rd(OFF_STATUS, 32'h02);
		irq_after(1'b0);
		wr(OFF_STATUS, 32'h01);
		irq_after(1'b1);
		wr(OFF_STATUS, 32'h03);
		irq_after(1'b0);
		expect_rd(OFF_STATUS, 32'h01);
		wr(OFF_STATUS, 32'h04);
		enc.strobe(1);
		irq_after(1'b1);
		expect_rd(OFF_STATUS, 32'h0c);
		wr(OFF_STATUS, 32'h0c);
		irq_after(1'b0);
		wr(OFF_IRQ_MASK, 32'h0);
		enc.strobe(1);
		irq_after(1'b0);
		expect_rd(OFF_STATUS, 32'h0c);
	endtask

	task automatic t_homing();
		logic hit;
		wr(OFF_IRQ_MASK, 32'h80);
		wr(OFF_STATUS, 32'h48);
		for (int m = 0; m < 8; m++) begin
			hit = (m == 3) || (m == 4);
			wr(OFF_MODE, 32'(m));
			expect_rd(OFF_MODE, 32'(m));
			enc.strobe(2);
			irq_after(hit);
			expect_rd(OFF_STATUS, {24'h0, hit, 7'h40});
			wr(OFF_STATUS, 32'hc0);
		end
	endtask

	task automatic t_unmapped();
		rd(8'h34);
		check({rdv[29:0], rsp}, {30'h0, RESP_SLVERR});
		rd(8'h05);
		check({rdv[29:0], rsp}, {30'h0, RESP_SLVERR});
		wr(8'h3c, 32'hffff);
		check({30'h0, rsp}, {30'h0, RESP_SLVERR});
	endtask

	initial begin
		{aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
		{s_axi_arvalid, s_axi_rready, s_axi_awprot, s_axi_arprot} = '0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		s_axi_wstrb = 4'h3;
		{miscompares, n_checks, stall, cyc} = '0;
		repeat (8) @(posedge aclk);
		aresetn <= 1'b1;
		t_read_write();
		t_hold_path();
		t_timer();
		t_events();
		t_homing();
		t_unmapped();
		close_out();
	end
endmodule

`default_nettype wire
